// ### inc/tbk_consts.svh
`ifndef TBK_CONSTS_SVH
`define TBK_CONSTS_SVH

// register byte offsets
`define TBK_OFS_BLOCK_CLOCK_SELECT 8'h04
`define TBK_OFS_TEST_COUNTER_LOAD 8'h40
`define TBK_OFS_TEST_CLOCK_OUTPUT_ENABLE 8'h44
`define TBK_OFS_TEST_STATUS 8'h48

// field positions in block_clock_select
`define TBK_SEL0_LSB 0
`define TBK_SEL1_LSB 2
`define TBK_SEL2_LSB 4
`define TBK_SEL_W 2

// reset values
`define TBK_BLOCK_CLOCK_SELECT_RST 6'h00
`define TBK_CLOCK_OUTPUT_RST 3'h0

// counter preload value for a test load
`define TBK_LOAD_VALUE 16'hfffe

// axi response codes
`define TBK_RESP_OKAY 2'h0
`define TBK_RESP_SLVERR 2'h2

`endif

// ### inc/tbk_pkg.sv
package tbk_pkg;

  typedef enum logic [1:0] {
    TBK_SEL_PIN = 2'h0,
    TBK_SEL_NONE = 2'h1,
    TBK_SEL_ALT_LO = 2'h2,
    TBK_SEL_ALT_HI = 2'h3
  } tbk_clk_sel_t;

  // write channel states, gray along idle -> resp
  typedef enum logic [1:0] {
    TBK_WR_IDLE = 2'h0,
    TBK_WR_RESP = 2'h1
  } tbk_wr_state_t;

endpackage

// ### inc/tbk_sel_if.sv
`timescale 1ns/10ps
interface tbk_sel_if;
  tbk_pkg::tbk_clk_sel_t code;
  logic pin;
  logic alt_lo;
  logic alt_hi;
  logic sel_out;

  modport ctrl (
    output code,
    output pin,
    output alt_lo,
    output alt_hi,
    input sel_out
  );

  modport mux (
    input code,
    input pin,
    input alt_lo,
    input alt_hi,
    output sel_out
  );
endinterface

// ### logic/tbk_clk_sel.sv
`timescale 1ns/10ps
module tbk_clk_sel (
  tbk_sel_if.mux sel
);

  always_comb
  begin
    case (sel.code)
      tbk_pkg::TBK_SEL_PIN: sel.sel_out = sel.pin;
      tbk_pkg::TBK_SEL_ALT_LO: sel.sel_out = sel.alt_lo;
      tbk_pkg::TBK_SEL_ALT_HI: sel.sel_out = sel.alt_hi;
      // no source: held low so the counter sees no edge
      default: sel.sel_out = 1'b0;
    endcase
  end

endmodule // tbk_clk_sel

// ### logic/tbk_block.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "tbk_consts.svh"
module tbk_block #(
  parameter int NCH = 3,
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // chip-level test mode level, asynchronous
  input wire logic special_function_mode_i,
  // dedicated timer clock pins, asynchronous
  input wire logic [NCH-1:0] timer_clk_pin_i,
  // channel side, same clock
  input wire logic [NCH-1:0] wave_a_out_i,
  input wire logic [NCH-1:0] cnt_clk_en_i,
  input wire logic [NCH-1:0] wave_b_norm_i,
  input wire logic [NCH-1:0] wave_b_norm_oe_n_i,
  output logic [NCH-1:0] ext_clock_o,
  output logic [NCH-1:0] load_counter_o,
  output logic [CNT_W-1:0] load_value_o,
  output logic [NCH-1:0] wave_b_pin_o,
  output logic [NCH-1:0] wave_b_pin_oe_n_o
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NCH-1:0] tclk_meta_reg;
  logic [NCH-1:0] tclk_sync_reg;
  logic sfm_meta_reg;
  logic test_mode_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tclk_meta_reg <= '0;
      tclk_sync_reg <= '0;
      sfm_meta_reg <= 1'b0;
      test_mode_reg <= 1'b0;
    end
    else
    begin
      tclk_meta_reg <= timer_clk_pin_i;
      tclk_sync_reg <= tclk_meta_reg;
      sfm_meta_reg <= special_function_mode_i;
      test_mode_reg <= sfm_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  tbk_pkg::tbk_wr_state_t wr_state_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  logic wr_hit_sel;
  logic wr_hit_load;
  logic wr_hit_oclk;
  logic wr_bad;

  assign s_axi_awready_o = !aw_have_reg
    && (wr_state_reg == tbk_pkg::TBK_WR_IDLE);
  assign s_axi_wready_o = !w_have_reg
    && (wr_state_reg == tbk_pkg::TBK_WR_IDLE);
  assign s_axi_bvalid_o = (wr_state_reg == tbk_pkg::TBK_WR_RESP);
  assign s_axi_bresp_o = bresp_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end
    else if (wr_fire)
      aw_have_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end
    else if (wr_fire)
      w_have_reg <= 1'b0;
  end

  // the write acts once both halves are held, whichever came first
  assign wr_fire = aw_have_reg && w_have_reg
    && (wr_state_reg == tbk_pkg::TBK_WR_IDLE);
  assign wr_hit_sel = (aw_addr_reg == `TBK_OFS_BLOCK_CLOCK_SELECT);
  // test registers are writable only inside test mode; reads are not gated
  assign wr_hit_load = (aw_addr_reg == `TBK_OFS_TEST_COUNTER_LOAD)
    && test_mode_reg;
  assign wr_hit_oclk = (aw_addr_reg == `TBK_OFS_TEST_CLOCK_OUTPUT_ENABLE)
    && test_mode_reg;
  assign wr_bad = !(wr_hit_sel || wr_hit_load || wr_hit_oclk);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_state_reg <= tbk_pkg::TBK_WR_IDLE;
      bresp_reg <= `TBK_RESP_OKAY;
    end
    else
    begin
      case (wr_state_reg)
        tbk_pkg::TBK_WR_IDLE:
        begin
          if (wr_fire)
          begin
            wr_state_reg <= tbk_pkg::TBK_WR_RESP;
            bresp_reg <= wr_bad ? `TBK_RESP_SLVERR : `TBK_RESP_OKAY;
          end
        end
        tbk_pkg::TBK_WR_RESP:
        begin
          if (s_axi_bready_i)
          begin
            wr_state_reg <= tbk_pkg::TBK_WR_IDLE;
          end
        end
        default: wr_state_reg <= tbk_pkg::TBK_WR_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [3*`TBK_SEL_W-1:0] clk_sel_reg;
  logic [NCH-1:0] clk_out_en_reg;
  logic [NCH-1:0] load_pulse_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      clk_sel_reg <= `TBK_BLOCK_CLOCK_SELECT_RST;
    else if (wr_fire && wr_hit_sel && w_strb_reg[0])
      clk_sel_reg <= w_data_reg[3*`TBK_SEL_W-1:0];
  end

  // enables drop with test mode so the pins fall back by themselves
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !test_mode_reg)
      clk_out_en_reg <= `TBK_CLOCK_OUTPUT_RST;
    else if (wr_fire && wr_hit_oclk && w_strb_reg[0])
      clk_out_en_reg <= w_data_reg[NCH-1:0];
  end

  // a one loads, a zero has no effect; one pulse per write
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      load_pulse_reg <= '0;
    else if (wr_fire && wr_hit_load && w_strb_reg[0])
      load_pulse_reg <= w_data_reg[NCH-1:0];
    else
      load_pulse_reg <= '0;
  end

  assign load_counter_o = load_pulse_reg;
  assign load_value_o = `TBK_LOAD_VALUE;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_word;
  logic rd_bad;

  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  always_comb
  begin
    rd_word = '0;
    rd_bad = 1'b0;
    case (s_axi_araddr_i)
      `TBK_OFS_BLOCK_CLOCK_SELECT:
      begin
        rd_word[3*`TBK_SEL_W-1:0] = clk_sel_reg;
      end
      // write-only: reads give zero
      `TBK_OFS_TEST_COUNTER_LOAD: rd_word = '0;
      `TBK_OFS_TEST_CLOCK_OUTPUT_ENABLE: rd_word = '0;
      `TBK_OFS_TEST_STATUS:
      begin
        rd_word[NCH-1:0] = clk_out_en_reg;
        rd_word[8] = test_mode_reg;
      end
      default: rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `TBK_RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_bad ? `TBK_RESP_SLVERR : `TBK_RESP_OKAY;
    end
    else if (rvalid_reg && s_axi_rready_i)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // external clock selection
  // ---------------------------------------------------------------
  logic [NCH-1:0] sel_out;
  logic [NCH-1:0] ext_clk_reg;

  for (genvar i = 0; i < NCH; i++)
  begin : g_sel
    tbk_sel_if sel_bus ();
    // ch0 alts 1,2; ch1 alts 0,2; ch2 alts 0,1
    localparam int LO = (i == 0) ? 1 : 0;
    localparam int HI = (i == 2) ? 1 : 2;
    assign sel_bus.code = tbk_pkg::tbk_clk_sel_t'(
      clk_sel_reg[i*`TBK_SEL_W +: `TBK_SEL_W]);
    assign sel_bus.pin = tclk_sync_reg[i];
    assign sel_bus.alt_lo = wave_a_out_i[LO];
    assign sel_bus.alt_hi = wave_a_out_i[HI];
    assign sel_out[i] = sel_bus.sel_out;
    tbk_clk_sel u_sel (
      .sel (sel_bus.mux)
    );
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ext_clk_reg <= '0;
    else
      ext_clk_reg <= sel_out;
  end

  assign ext_clock_o = ext_clk_reg;

  // ---------------------------------------------------------------
  // b pin override
  // ---------------------------------------------------------------
  logic [NCH-1:0] b_pin_reg;
  logic [NCH-1:0] b_oe_n_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      b_pin_reg <= '0;
      b_oe_n_reg <= '1;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (clk_out_en_reg[i])
        begin
          b_pin_reg[i] <= cnt_clk_en_i[i];
          b_oe_n_reg[i] <= 1'b0;
        end
        else
        begin
          b_pin_reg[i] <= wave_b_norm_i[i];
          b_oe_n_reg[i] <= wave_b_norm_oe_n_i[i];
        end
      end
    end
  end

  assign wave_b_pin_o = b_pin_reg;
  assign wave_b_pin_oe_n_o = b_oe_n_reg;

endmodule // tbk_block

// ### tb/tbk_block_monitor.sv
`timescale 1ns/10ps
// ------------------------------------------
// port-level checks
// ------------------------------------------
module tbk_block_monitor #(
  parameter int NCH = 3,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NCH-1:0] load_counter_o,
  input wire logic [CNT_W-1:0] load_value_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  a_load_value: assert property (load_value_o == 16'hfffe)
    else $error("load value wrong");
  // load must be one cycle, riding on the write answer
  a_load_pulse: assert property (|load_counter_o |->
    $rose(s_axi_bvalid_o) ##1 load_counter_o == '0)
    else $error("load pulse wrong");
  a_write_order: assert property ($rose(s_axi_bvalid_o) |->
    $past(!s_axi_awready_o && !s_axi_wready_o))
    else $error("write answer without request");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  a_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    s_axi_awready_o && s_axi_wready_o && !s_axi_bvalid_o)
    else $error("write channel not freed");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o)
    else $error("read answer dropped");
  a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
endmodule // tbk_block_monitor

bind tbk_block tbk_block_monitor #(.NCH(NCH), .CNT_W(CNT_W)) mon_i (
  .clk_i, .srst_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .load_counter_o, .load_value_o);

// ### tb/tbk_block_tb.sv
`timescale 1ns/10ps
module tbk_block_tb;
  logic clk = '0, rst = '1, awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
  logic special_function_mode = '0, bq = '0, pk = '0;
  logic [7:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, seed = 32'h3;
  logic [2:0] tp = '0, wa = '0, ce = '0, bn = '0, bo = '0, ext, ld, bp, boe;
  logic [1:0] bresp, rresp;
  logic [5:0] s;
  logic [15:0] lv;
  logic awr, wrd, bv, arr, rv;
  logic [33:0] er[$];
  logic [4:0] eb[$];
  logic [8:0] ep[$];
  int err_total = 0, num_checks = 0;

  initial forever #5 clk = ~clk;

  tbk_block tbk_block_i (.clk_i(clk), .srst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .special_function_mode_i(special_function_mode), .timer_clk_pin_i(tp),
    .wave_a_out_i(wa), .cnt_clk_en_i(ce), .wave_b_norm_i(bn),
    .wave_b_norm_oe_n_i(bo), .ext_clock_o(ext), .load_counter_o(ld),
    .load_value_o(lv), .wave_b_pin_o(bp), .wave_b_pin_oe_n_o(boe));

  // ------------------------------------------
  // checking helpers
  // ------------------------------------------
  task automatic tally(input bit ok, input string k);
    num_checks++;
    if (!ok)
    begin
      err_total++;
      $display("ERROR %0t %s mismatch", $time, k);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] g, e);
    tally(g === e, "read");
  endtask
  task automatic cmp_wr(input logic [4:0] g, e);
    tally(g === e, "write");
  endtask
  task automatic cmp_pin(input logic [8:0] g, e);
    tally(g === e, "pin");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] ext_exp(input logic [5:0] c,
                                         input logic [2:0] a, p);
    logic [2:0] x;
    for (int n = 0; n < 3; n++)
      case (c[2*n +: 2])
        2'h0: x[n] = p[n];
        2'h1: x[n] = 1'h0;
        2'h2: x[n] = a[n == 0 ? 1 : 0];
        default: x[n] = a[n == 2 ? 1 : 2];
      endcase
    return x;
  endfunction

  // ready raised late on purpose, so the answers must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [4:0] e);
    bit dn;
    eb.push_back(e);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    dn = 0;
    for (int n = 0; n < 50 && !dn; n++)
    begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      dn = bv && br;
      br <= n > 1 && !dn;
    end
    tally(dn, "write wait");
    @(posedge clk);
  endtask
  task automatic rdq(input logic [7:0] a, input logic [33:0] e);
    bit dn;
    er.push_back(e);
    ara <= a;
    arv <= 1'h1;
    dn = 0;
    for (int n = 0; n < 50 && !dn; n++)
    begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      dn = rv && rr;
      rr <= n > 0 && !dn;
    end
    tally(dn, "read wait");
    @(posedge clk);
  endtask
  // pins are compared one edge later, once the outputs have settled
  task automatic pin(input logic [8:0] e);
    ep.push_back(e);
    pk <= 1'h1;
    @(posedge clk);
    pk <= 1'h0;
  endtask

  always @(posedge clk)
  begin
    bq <= bv;
    if (rv && rr && er.size() > 0)
      cmp_rd({rresp, rd}, er.pop_front());
    if (bv && !bq && eb.size() > 0)
      cmp_wr({bresp, ld}, eb.pop_front());
    if (pk && ep.size() > 0)
      cmp_pin({ext, bp, boe}, ep.pop_front());
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdq(8'h04, 34'h0);
    rdq(8'h10, {2'h2, 32'h0});
    wr(8'h40, 32'h7, 5'h10);
    wr(8'h44, 32'h7, 5'h10);
    for (int i = 0; i < 4; i++)
    begin
      s = {2'(i + 2), 2'(i + 1), 2'(i)};
      wr(8'h04, {26'h0, s}, 5'h0);
      rdq(8'h04, {28'h0, s});
      repeat (3)
      begin
        seed = nxt(seed);
        tp <= seed[2:0];
        wa <= seed[5:3];
        repeat (4) @(posedge clk);
        pin({ext_exp(s, wa, tp), bn, bo});
      end
    end
    special_function_mode <= 1'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      seed = nxt(seed);
      wr(8'h40, {seed[31:3], 3'h1 << i}, {2'h0, 3'h1 << i});
    end
    rdq(8'h40, 34'h0);
    rdq(8'h44, 34'h0);
    wr(8'h44, 32'h4, 5'h0);
    rdq(8'h48, {2'h0, 32'h104});
    seed = nxt(seed);
    ce <= seed[2:0];
    bn <= seed[5:3];
    bo <= seed[8:6];
    repeat (2) @(posedge clk);
    pin({ext_exp(s, wa, tp), ce[2], bn[1:0], 1'h0, bo[1:0]});
    wr(8'h44, 32'h3, 5'h0);
    repeat (2) @(posedge clk);
    pin({ext_exp(s, wa, tp), bn[2], ce[1:0], bo[2], 2'h0});
    special_function_mode <= 1'h0;
    repeat (4) @(posedge clk);
    pin({ext_exp(s, wa, tp), bn, bo});
    wr(8'h40, 32'h7, 5'h10);
    complete_run;
  end
endmodule // tbk_block_tb
